// ==== design/usb_endpoint_control_regs.sv ====
// endpoint control registers, DMA pause gating and next-descriptor pointers
// Behaviour
// - pause bit set: any endpoint interrupt pauses its DMA, enable ignored
// - new-bank interrupt: previous bank finishes, new bank not requested
// - other pausing interrupts withdraw the request and pause at once
// - control endpoints: handover and read-write-allowed always read zero
// - IN endpoint: handover sets when bank frees, with sent flag
// - IN endpoint: clearing handover commits bank data and advances bank
// - OUT endpoint: handover sets when bank fills, with received flag
// - OUT endpoint: clearing handover releases bank and advances bank
// - kill set starts discarding last IN bank; hardware clears when done
// - kill end decrements busy banks; sent-instead also sets sent flag
// - two banks ready: first is sent, last is killed
// - busy-bank interrupt enable set and cleared by write-one bits
// - enables 7..0 set by set-register ones, cleared by clear-register ones
// - bits 6 and 2 enable one of two interrupts by endpoint type
// - clear register clears written ones, reads zero, 4-byte stride
// - set register sets written ones, leaves zeros, 4-byte stride
// - stall request set and cleared at bit 19; toggle reset set at 18
// - next-descriptor per channel, bits 31:4, resets zero, 16-byte stride
// - stall request answers STALL and self-clears on new SETUP
// - toggle reset forces DATA0 next and clears itself at once
// - next-descriptor written by software or by descriptor loading
//
// The strobed register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "usb_ep_ctrl_cfg.svh"

module usb_endpoint_control_regs
	import usb_ep_pkg::*;
(
	input  wire logic                     sys_clk,
	input  wire logic                     rst_n,
	input  wire logic [`BUS_ADDR_W-1:0]   bus_addr,
	input  wire logic [31:0]              bus_wdata,
	input  wire logic                     bus_wr,
	input  wire logic                     bus_rd,
	output logic [31:0]                   bus_rdata,
	input  wire ep_type_t                 ep_type [`EP_COUNT],
	input  wire ep_evt_t                  ep_evt [`EP_COUNT],
	input  wire logic [1:0]               busy_bank_count [`EP_COUNT],
	output ep_cmd_t                       ep_cmd [`EP_COUNT],
	input  wire logic [`DMA_CHANNELS-1:0] dma_want,
	input  wire logic [`DMA_CHANNELS-1:0] dma_on_prev,
	output logic [`DMA_CHANNELS-1:0]      dma_request,
	output logic [`DMA_CHANNELS-1:0]      dma_pause_now,
	input  wire logic [`DMA_CHANNELS-1:0] desc_load,
	input  wire logic [27:0]              desc_addr [`DMA_CHANNELS],
	output logic [27:0]                   next_descriptor_pointer [`DMA_CHANNELS]
);

	logic [`EP_COUNT-1:0]     set_wr;
	logic [`EP_COUNT-1:0]     clr_wr;
	logic [`DMA_CHANNELS-1:0] desc_wr;
	logic [31:0]              ctrl_word [`EP_COUNT];
	logic [31:0]              next_rdata;

	////////////////////////////////////////////////////////////////////////
	// write decode

	always_comb
	begin
		for (int i = 0; i < `EP_COUNT; i++)
		begin
			set_wr[i] = bus_wr &&
				(bus_addr == `CTRL_SET_BASE + `EP_STRIDE * 12'(i));
			clr_wr[i] = bus_wr &&
				(bus_addr == `CTRL_CLR_BASE + `EP_STRIDE * 12'(i));
		end
		for (int c = 0; c < `DMA_CHANNELS; c++)
			desc_wr[c] = bus_wr &&
				(bus_addr == `NEXTDESC_BASE + `DMA_STRIDE * 12'(c));
	end

	////////////////////////////////////////////////////////////////////////
	// per-endpoint control words

	generate
		for (genvar g = 0; g < `EP_COUNT; g++)
		begin : gen_ep
			ep_ctrl_word u_word (
				.sys_clk         (sys_clk),
				.rst_n           (rst_n),
				.ep_type         (ep_type[g]),
				.set_wr          (set_wr[g]),
				.clr_wr          (clr_wr[g]),
				.wdata           (bus_wdata),
				.evt             (ep_evt[g]),
				.busy_bank_count (busy_bank_count[g]),
				.ctrl_word       (ctrl_word[g]),
				.cmd             (ep_cmd[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// DMA gating, channel c serves endpoint c+1

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dma_request <= '0;
			dma_pause_now <= '0;
		end
		else
		begin
			for (int c = 0; c < `DMA_CHANNELS; c++)
			begin
				// any flag pauses, whatever the interrupt enables say
				dma_request[c] <= dma_want[c] &&
					!(ctrl_word[c+1][`BIT_DMA_PAUSE] &&
					((|ep_evt[c+1].flags) || ep_evt[c+1].busy_flag));
				// new-bank flags leave the previous-bank transfer running
				dma_pause_now[c] <= ctrl_word[c+1][`BIT_DMA_PAUSE] &&
					((|ep_evt[c+1].flags[7:`NEW_BANK_MSB+1]) ||
					ep_evt[c+1].busy_flag ||
					((|ep_evt[c+1].flags[`NEW_BANK_MSB:0]) && !dma_on_prev[c]));
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// next-descriptor pointers

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int c = 0; c < `DMA_CHANNELS; c++)
				next_descriptor_pointer[c] <= `NEXTDESC_RESET;
		end
		else
		begin
			for (int c = 0; c < `DMA_CHANNELS; c++)
			begin
				if (desc_wr[c])
					next_descriptor_pointer[c] <= bus_wdata[31:`NEXTDESC_LSB];
				else if (desc_load[c])
					next_descriptor_pointer[c] <= desc_addr[c];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read path, data one cycle after the strobe

	always_comb
	begin
		next_rdata = `READ_ZERO;
		for (int i = 0; i < `EP_COUNT; i++)
			if (bus_addr == `CTRL_BASE + `EP_STRIDE * 12'(i))
				next_rdata = ctrl_word[i];
		for (int c = 0; c < `DMA_CHANNELS; c++)
			if (bus_addr == `NEXTDESC_BASE + `DMA_STRIDE * 12'(c))
				next_rdata = {next_descriptor_pointer[c], 4'h0};
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			bus_rdata <= `READ_ZERO;
		else if (bus_rd)
			bus_rdata <= next_rdata;
		else
			bus_rdata <= `READ_ZERO;
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	sequence toggle_pulse_s(int k);
		ep_cmd[k].toggle_reset ##1 !ctrl_word[k][`BIT_TOGGLE_RST];
	endsequence

	sequence advance_s(int k);
		!ctrl_word[k][`BIT_HANDOVER] && ep_cmd[k].bank_advance;
	endsequence

	sequence kill_closed_s(int k);
		ep_cmd[k].busy_bank_dec && !ctrl_word[k][`BIT_KILL];
	endsequence

	generate
		for (genvar a = 0; a < `EP_COUNT; a++)
		begin : gen_chk
			irq_en_set_a: assert property (
				set_wr[a] |=> ((ctrl_word[a][7:0] & $past(bus_wdata[7:0]))
					== $past(bus_wdata[7:0])))
				else $error("interrupt enable not set");

			irq_en_clear_a: assert property (
				clr_wr[a] |=> ((ctrl_word[a][7:0] & $past(bus_wdata[7:0])) == 8'h00))
				else $error("interrupt enable not cleared");

			set_keeps_zero_a: assert property (
				set_wr[a] |=> ((ctrl_word[a][7:0] & ~$past(bus_wdata[7:0]))
					== ($past(ctrl_word[a][7:0]) & ~$past(bus_wdata[7:0]))))
				else $error("set write disturbed other enables");

			busy_irq_en_a: assert property (
				clr_wr[a] && bus_wdata[`BIT_BUSY_IRQ_EN]
				|=> !ctrl_word[a][`BIT_BUSY_IRQ_EN])
				else $error("busy bank enable not cleared");

			ctrl_ep_zero_a: assert property (
				ep_type[a] == EP_CONTROL
				|-> !ctrl_word[a][`BIT_HANDOVER] ##1
				(!ep_cmd[a].read_write_allowed || $past(ep_type[a]) != EP_CONTROL))
				else $error("control endpoint shows handover bits");

			handover_set_a: assert property (
				ep_evt[a].bank_done && ep_type[a] != EP_CONTROL
				&& !clr_wr[a] |=> ctrl_word[a][`BIT_HANDOVER]
				|| $past(ep_type[a]) == EP_CONTROL)
				else $error("handover not set with bank event");

			handover_clear_a: assert property (
				clr_wr[a] && bus_wdata[`BIT_HANDOVER] && ctrl_word[a][`BIT_HANDOVER]
				&& ep_type[a] != EP_CONTROL |=> advance_s(a))
				else $error("handover clear did not advance bank");

			stall_setup_a: assert property (
				ep_evt[a].setup_rcvd && !set_wr[a] |=> !ep_cmd[a].stall_request)
				else $error("stall not dropped on setup");

			stall_set_a: assert property (
				set_wr[a] && bus_wdata[`BIT_STALL] |=> ep_cmd[a].stall_request [*1]
				##0 ctrl_word[a][`BIT_STALL])
				else $error("stall request not set");

			toggle_reset_a: assert property (
				set_wr[a] && bus_wdata[`BIT_TOGGLE_RST] && !$past(set_wr[a])
				|=> toggle_pulse_s(a))
				else $error("toggle reset not a single pulse");

			kill_set_a: assert property (
				set_wr[a] && bus_wdata[`BIT_KILL] && ep_type[a] == EP_IN
				&& !ctrl_word[a][`BIT_KILL]
				|=> ctrl_word[a][`BIT_KILL] && ep_cmd[a].kill_start)
				else $error("kill not started");

			kill_end_a: assert property (
				ctrl_word[a][`BIT_KILL] && ep_evt[a].kill_done && !set_wr[a]
				|=> ep_cmd[a].busy_bank_dec && !ctrl_word[a][`BIT_KILL])
				else $error("kill end did not decrement busy banks");

			two_bank_kill_a: assert property (
				busy_bank_count[a] == 2'h2 |=> !ep_cmd[a].in_sent_set)
				else $error("sent-instead with two busy banks");

			rw_allowed_a: assert property (
				ep_evt[a].rw_allowed && ep_type[a] != EP_CONTROL
				|=> ep_cmd[a].read_write_allowed)
				else $error("read-write allowed not passed on");

			sent_instead_a: assert property (
				ctrl_word[a][`BIT_KILL] && ep_evt[a].kill_sent && !set_wr[a]
				&& busy_bank_count[a] == 2'h1
				|=> kill_closed_s(a) ##0 ep_cmd[a].in_sent_set)
				else $error("sent-instead kill not closed");

			kill_non_in_a: assert property (
				set_wr[a] && bus_wdata[`BIT_KILL] && ep_type[a] != EP_IN
				&& !ctrl_word[a][`BIT_KILL] |=> !ctrl_word[a][`BIT_KILL])
				else $error("kill set on a non-IN endpoint");

			kill_hold_a: assert property (
				ctrl_word[a][`BIT_KILL] && !ep_evt[a].kill_done && !ep_evt[a].kill_sent
				|=> ctrl_word[a][`BIT_KILL])
				else $error("kill dropped without an end event");

			ctrl_read_a: assert property (
				bus_rd && bus_addr == `CTRL_BASE + `EP_STRIDE * 12'(a)
				|=> bus_rdata == $past(ctrl_word[a]))
				else $error("control word readback wrong");

			toggle_once_a: assert property (
				ep_cmd[a].toggle_reset |=> !ep_cmd[a].toggle_reset
				|| ($past(set_wr[a]) && $past(bus_wdata[`BIT_TOGGLE_RST])))
				else $error("toggle reset held over");

			stall_hold_a: assert property (
				!set_wr[a] && !clr_wr[a] && !ep_evt[a].setup_rcvd
				|=> $stable(ep_cmd[a].stall_request))
				else $error("stall request changed by itself");
		end

		for (genvar d = 0; d < `DMA_CHANNELS; d++)
		begin : gen_dma_chk
			pause_any_a: assert property (
				ctrl_word[d+1][`BIT_DMA_PAUSE] && (|ep_evt[d+1].flags)
				|=> !dma_request[d])
				else $error("request not withdrawn on interrupt");

			new_bank_prev_a: assert property (
				ctrl_word[d+1][`BIT_DMA_PAUSE] && dma_on_prev[d]
				&& ep_evt[d+1].flags[7:`NEW_BANK_MSB+1] == 6'h00
				&& !ep_evt[d+1].busy_flag |=> !dma_pause_now[d])
				else $error("previous bank paused on new-bank event");

			nak_pause_a: assert property (
				ctrl_word[d+1][`BIT_DMA_PAUSE] && (|ep_evt[d+1].flags[4:3])
				|=> dma_pause_now[d])
				else $error("no immediate pause on NAK");

			desc_write_a: assert property (
				desc_wr[d] ##1 bus_rd && bus_addr == $past(bus_addr)
				|=> bus_rdata == {$past(bus_wdata[31:`NEXTDESC_LSB], 2), 4'h0})
				else $error("next descriptor readback wrong");

			desc_load_a: assert property (
				desc_load[d] && !desc_wr[d]
				|=> next_descriptor_pointer[d] == $past(desc_addr[d]))
				else $error("descriptor load not taken");

			request_resume_a: assert property (
				dma_want[d] && !ctrl_word[d+1][`BIT_DMA_PAUSE] |=> dma_request[d])
				else $error("request held back without pause bit");

			no_pause_off_a: assert property (
				!ctrl_word[d+1][`BIT_DMA_PAUSE] |=> !dma_pause_now[d])
				else $error("pause without pause bit");

			desc_hold_a: assert property (
				!desc_wr[d] && !desc_load[d] |=> $stable(next_descriptor_pointer[d]))
				else $error("next descriptor changed by itself");
		end
	endgenerate

	set_reads_zero_a: assert property (
		bus_rd && bus_addr >= `CTRL_SET_BASE && bus_addr < `NEXTDESC_BASE
		|=> bus_rdata == `READ_ZERO)
		else $error("write-only register read nonzero");

	rdata_idle_a: assert property (
		!bus_rd |=> bus_rdata == `READ_ZERO)
		else $error("read data not zero after read cycle");

endmodule

`default_nettype wire

// ==== design/usb_ep_ctrl_cfg.svh ====
// register map, field positions and reset values of the endpoint control block
`ifndef USB_EP_CTRL_CFG_SVH
`define USB_EP_CTRL_CFG_SVH

`define EP_COUNT          7
`define DMA_CHANNELS      6
`define BUS_ADDR_W        12

`define CTRL_BASE         12'h1C0
`define CTRL_SET_BASE     12'h1F0
`define CTRL_CLR_BASE     12'h220
`define EP_STRIDE         12'h004
`define NEXTDESC_BASE     12'h310
`define DMA_STRIDE        12'h010

`define CTRL_RESET        32'h0000_0000
`define NEXTDESC_RESET    28'h000_0000
`define READ_ZERO         32'h0000_0000

`define BIT_IRQ_EN_MSB    7
`define BIT_BUSY_IRQ_EN   12
`define BIT_KILL          13
`define BIT_HANDOVER      14
`define BIT_DMA_PAUSE     16
`define BIT_TOGGLE_RST    18
`define BIT_STALL         19
`define NEXTDESC_LSB      4
`define NEW_BANK_MSB      1

`endif

// ==== design/usb_ep_pkg.sv ====
// types shared by the endpoint control block and its per-endpoint word
package usb_ep_pkg;

	typedef enum logic [1:0] {EP_CONTROL, EP_IN, EP_OUT} ep_type_t;

	// events from the packet engine, all one-cycle pulses except levels noted
	typedef struct packed {
		logic       bank_done;
		logic       setup_rcvd;
		logic       kill_done;
		logic       kill_sent;
		logic       busy_flag;
		logic       rw_allowed;
		logic [7:0] flags;
	} ep_evt_t;

	// commands and levels towards the packet engine
	typedef struct packed {
		logic bank_advance;
		logic kill_start;
		logic busy_bank_dec;
		logic in_sent_set;
		logic toggle_reset;
		logic stall_request;
		logic read_write_allowed;
		logic endpoint_interrupt;
	} ep_cmd_t;

endpackage

// ==== design/ep_ctrl_word.sv ====
// control word of one endpoint: set/clear bits and engine commands
`timescale 1ns/100ps
`default_nettype none
`include "usb_ep_ctrl_cfg.svh"

module ep_ctrl_word
	import usb_ep_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire ep_type_t    ep_type,
	input  wire logic        set_wr,
	input  wire logic        clr_wr,
	input  wire logic [31:0] wdata,
	input  wire ep_evt_t     evt,
	input  wire logic [1:0]  busy_bank_count,
	output logic [31:0]      ctrl_word,
	output ep_cmd_t          cmd
);

	logic [31:0] set_b;
	logic [31:0] clr_b;
	logic [7:0]  irq_en;
	logic        busy_en;
	logic        dma_pause;
	logic        stall;
	logic        handover;
	logic        kill;
	logic        toggle;
	logic        advance;
	logic        kill_go;
	logic        busy_dec;
	logic        sent_set;
	logic        rw_ok;
	logic        ep_irq;
	logic        is_ctrl;
	logic        is_in;
	logic        single_bank;
	logic        kill_end;

	assign set_b = set_wr ? wdata : `READ_ZERO;
	assign clr_b = clr_wr ? wdata : `READ_ZERO;
	assign is_ctrl = (ep_type == EP_CONTROL);
	assign is_in = (ep_type == EP_IN);
	// an IN token only replaces the kill while a single bank is busy
	assign single_bank = (busy_bank_count == 2'h1);
	assign kill_end = evt.kill_done | (evt.kill_sent & single_bank);

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_en <= 8'h00;
			busy_en <= 1'b0;
			dma_pause <= 1'b0;
		end
		else
		begin
			irq_en <= (irq_en | set_b[`BIT_IRQ_EN_MSB:0]) & ~clr_b[`BIT_IRQ_EN_MSB:0];
			busy_en <= (busy_en | set_b[`BIT_BUSY_IRQ_EN]) & ~clr_b[`BIT_BUSY_IRQ_EN];
			dma_pause <= (dma_pause | set_b[`BIT_DMA_PAUSE]) & ~clr_b[`BIT_DMA_PAUSE];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			stall <= 1'b0;
		else if (set_b[`BIT_STALL] | clr_b[`BIT_STALL])
			stall <= set_b[`BIT_STALL];
		else if (evt.setup_rcvd)
			stall <= 1'b0;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			handover <= 1'b0;
		else if (is_ctrl)
			handover <= 1'b0;
		else if (clr_b[`BIT_HANDOVER])
			handover <= 1'b0;
		else if (evt.bank_done)
			handover <= 1'b1;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			kill <= 1'b0;
		else if (set_b[`BIT_KILL] & is_in)
			kill <= 1'b1;
		else if (kill_end)
			kill <= 1'b0;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			toggle <= 1'b0;
			advance <= 1'b0;
			kill_go <= 1'b0;
			busy_dec <= 1'b0;
			sent_set <= 1'b0;
			rw_ok <= 1'b0;
			ep_irq <= 1'b0;
		end
		else
		begin
			toggle <= set_b[`BIT_TOGGLE_RST];
			advance <= clr_b[`BIT_HANDOVER] & handover & ~is_ctrl;
			kill_go <= set_b[`BIT_KILL] & ~kill & is_in;
			busy_dec <= kill & kill_end;
			sent_set <= kill & evt.kill_sent & single_bank;
			rw_ok <= evt.rw_allowed & ~is_ctrl;
			ep_irq <= (|(evt.flags & irq_en)) | (evt.busy_flag & busy_en);
		end
	end

	assign ctrl_word = {12'h000, stall, toggle, 1'b0, dma_pause, 1'b0,
		handover & ~is_ctrl, kill, busy_en, 4'h0, irq_en};
	assign cmd = '{bank_advance: advance, kill_start: kill_go,
		busy_bank_dec: busy_dec, in_sent_set: sent_set,
		toggle_reset: toggle, stall_request: stall,
		read_write_allowed: rw_ok, endpoint_interrupt: ep_irq};

endmodule

`default_nettype wire

// ==== tb/ep_engine_model.sv ====
// behavioural packet engine on the far side of the endpoint control block
`timescale 1ns/100ps
`default_nettype none
`include "usb_ep_ctrl_cfg.svh"

module ep_engine_model
	import usb_ep_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic [3:0] kill_delay,
	input  wire ep_cmd_t    ep_cmd [`EP_COUNT],
	input  wire ep_evt_t    evt_in [`EP_COUNT],
	output var ep_evt_t     evt_out [`EP_COUNT],
	output logic [1:0]      busy [`EP_COUNT]
);
	logic [4:0]           cnt [`EP_COUNT];
	logic [`EP_COUNT-1:0] done;
	always_comb
	begin
		for (int e = 0; e < `EP_COUNT; e++)
		begin
			evt_out[e]           = evt_in[e];
			evt_out[e].kill_done = done[e];
		end
	end
	// kill ends kill_delay+2 cycles after its start command
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		for (int e = 0; e < `EP_COUNT; e++)
		begin
			if (!rst_n)
			begin
				cnt[e]  <= 5'h00;
				done[e] <= 1'b0;
				busy[e] <= 2'h1;
			end
			else
			begin
				done[e] <= (cnt[e] == 5'h01);
				if (ep_cmd[e].kill_start)
					cnt[e] <= {1'b0, kill_delay} + 5'h01;
				else if (cnt[e] != 5'h00)
					cnt[e] <= cnt[e] - 5'h01;
				if (ep_cmd[e].busy_bank_dec && busy[e] != 2'h0)
					busy[e] <= busy[e] - 2'h1;
				else if (ep_cmd[e].bank_advance && busy[e] != 2'h3)
					busy[e] <= busy[e] + 2'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench of the endpoint control registers
`timescale 1ns/100ps
`default_nettype none
`include "usb_ep_ctrl_cfg.svh"

module tb
	import usb_ep_pkg::*;
;
	localparam logic [31:0] RND_MASK = 32'h0009_10FF;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [11:0] bus_addr = 12'h000;
	logic [31:0] bus_wdata = 32'h0000_0000;
	logic        bus_wr = 1'b0;
	logic        bus_rd = 1'b0;
	logic [31:0] bus_rdata;
	ep_type_t    ep_type [7];
	ep_evt_t     ev [7];
	ep_evt_t     evt [7];
	logic [1:0]  busy [7];
	ep_cmd_t     ep_cmd [7];
	logic [5:0]  dma_want = 6'h00;
	logic [5:0]  dma_on_prev = 6'h00;
	logic [5:0]  dma_request;
	logic [5:0]  dma_pause_now;
	logic [5:0]  desc_load = 6'h00;
	logic [27:0] desc_addr [6];
	logic [27:0] next_descriptor_pointer [6];
	logic [3:0]  kill_delay = 4'h0;
	logic [31:0] exp_w [7];
	int          errors = 0;
	int          cmp_count = 0;
	always #25 sys_clk = ~sys_clk;
	usb_endpoint_control_regs uut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.ep_type(ep_type), .ep_evt(evt), .busy_bank_count(busy), .ep_cmd(ep_cmd),
		.dma_want(dma_want), .dma_on_prev(dma_on_prev), .dma_request(dma_request),
		.dma_pause_now(dma_pause_now), .desc_load(desc_load), .desc_addr(desc_addr),
		.next_descriptor_pointer(next_descriptor_pointer));
	ep_engine_model model (.sys_clk(sys_clk), .rst_n(rst_n), .kill_delay(kill_delay),
		.ep_cmd(ep_cmd), .evt_in(ev), .evt_out(evt), .busy(busy));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [11:0] ea(input logic [11:0] b, input int e);
		return b + 12'(4 * e);
	endfunction
	task automatic close_out();
		if (errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk32({31'h0, got}, {31'h0, exp});
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		bus_addr  <= a;
		bus_wdata <= d;
		bus_wr    <= 1'b1;
		@(posedge sys_clk);
		bus_wr <= 1'b0;
		#1;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		bus_addr <= a;
		bus_rd   <= 1'b1;
		@(posedge sys_clk);
		bus_rd <= 1'b0;
		#1 chk32(bus_rdata, e);
	endtask
	task automatic evp(input int e, input ep_evt_t m);
		@(posedge sys_clk);
		ev[e] <= ev[e] | m;
		@(posedge sys_clk);
		ev[e] <= ev[e] & ~m;
		#1;
	endtask
	task automatic settle();
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		logic [31:0] r;
		logic [31:0] m;
		ep_evt_t     bd;
		ep_evt_t     su;
		ep_evt_t     ks;
		logic        ok;
		int          e;
		r = 32'h0000_004F;
		bd = '0;
		bd.bank_done = 1'b1;
		su = '0;
		su.setup_rcvd = 1'b1;
		ks = '0;
		ks.kill_sent = 1'b1;
		for (int i = 0; i < 7; i++)
		begin
			ev[i] = '0;
			exp_w[i] = 32'h0;
			ep_type[i] = (i == 0) ? EP_CONTROL : ((i < 4) ? EP_IN : EP_OUT);
		end
		for (int i = 0; i < 6; i++)
			desc_addr[i] = 28'h000_0000;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 7; i++)
			rchk(ea(`CTRL_BASE, i), 32'h0);
		for (int i = 0; i < 6; i++)
			rchk(`NEXTDESC_BASE + 12'(16 * i), 32'h0);
		for (int k = 0; k < 24; k++)
		begin
			r = nxt(r);
			e = int'(r[2:0]) % 7;
			m = nxt(r) & RND_MASK;
			wr(ea(`CTRL_SET_BASE, e), m);
			exp_w[e] = exp_w[e] | m;
			r = nxt(nxt(r));
			m = r & RND_MASK;
			wr(ea(`CTRL_CLR_BASE, e), m);
			exp_w[e] = exp_w[e] & ~m;
			rchk(ea(`CTRL_BASE, e), exp_w[e]);
		end
		for (int i = 0; i < 7; i++)
			wr(ea(`CTRL_CLR_BASE, i), RND_MASK);
		rchk(`CTRL_SET_BASE, 32'h0);
		rchk(ea(`CTRL_CLR_BASE, 6), 32'h0);
		rchk(12'h0FC, 32'h0);
		wr(ea(`CTRL_SET_BASE, 5), 32'h0000_1002);
		@(posedge sys_clk);
		ev[5].flags <= 8'h02;
		settle();
		chk1(ep_cmd[5].endpoint_interrupt, 1'b1);
		wr(ea(`CTRL_CLR_BASE, 5), 32'h0000_0002);
		settle();
		chk1(ep_cmd[5].endpoint_interrupt, 1'b0);
		ev[5].busy_flag <= 1'b1;
		settle();
		chk1(ep_cmd[5].endpoint_interrupt, 1'b1);
		wr(ea(`CTRL_CLR_BASE, 5), 32'h0000_1000);
		settle();
		chk1(ep_cmd[5].endpoint_interrupt, 1'b0);
		ev[5] <= '0;
		wr(ea(`CTRL_SET_BASE, 4), 32'h0004_0000);
		chk1(ep_cmd[4].toggle_reset, 1'b1);
		@(posedge sys_clk);
		#1 chk1(ep_cmd[4].toggle_reset, 1'b0);
		wr(`CTRL_SET_BASE, 32'h0008_0000);
		chk1(ep_cmd[0].stall_request, 1'b1);
		evp(0, su);
		chk1(ep_cmd[0].stall_request, 1'b0);
		wr(`CTRL_SET_BASE, 32'h0008_0000);
		wr(`CTRL_CLR_BASE, 32'h0008_0000);
		chk1(ep_cmd[0].stall_request, 1'b0);
		evp(0, bd);
		rchk(`CTRL_BASE, 32'h0);
		ev[0].rw_allowed <= 1'b1;
		ev[6].rw_allowed <= 1'b1;
		settle();
		chk1(ep_cmd[0].read_write_allowed, 1'b0);
		chk1(ep_cmd[6].read_write_allowed, 1'b1);
		for (int j = 0; j < 2; j++)
		begin
			e = 1 + 4 * j;
			evp(e, bd);
			rchk(ea(`CTRL_BASE, e), 32'h0000_4000);
			wr(ea(`CTRL_CLR_BASE, e), 32'h0000_4000);
			chk1(ep_cmd[e].bank_advance, 1'b1);
			rchk(ea(`CTRL_BASE, e), 32'h0);
		end
		for (int j = 0; j < 2; j++)
		begin
			e = 2 + j;
			kill_delay <= 4'(6 * j);
			wr(ea(`CTRL_SET_BASE, e), 32'h0000_2000);
			chk1(ep_cmd[e].kill_start, 1'b1);
			if (j == 1)
				rchk(ea(`CTRL_BASE, e), 32'h0000_2000);
			ok = 1'b0;
			for (int t = 0; t < 30 && !ok; t++)
			begin
				@(posedge sys_clk);
				#1 ok = (ep_cmd[e].busy_bank_dec === 1'b1);
			end
			chk1(ok, 1'b1);
			if (!ok)
				close_out();
			rchk(ea(`CTRL_BASE, e), 32'h0);
		end
		wr(ea(`CTRL_SET_BASE, 5), 32'h0000_2000);
		rchk(ea(`CTRL_BASE, 5), 32'h0);
		// one busy bank on endpoint 2, two on endpoint 1
		evp(2, bd);
		wr(ea(`CTRL_CLR_BASE, 2), 32'h0000_4000);
		kill_delay <= 4'hF;
		for (int j = 1; j < 3; j++)
		begin
			wr(ea(`CTRL_SET_BASE, j), 32'h0000_2000);
			evp(j, ks);
			chk1(ep_cmd[j].in_sent_set, j == 2);
			chk1(ep_cmd[j].busy_bank_dec, j == 2);
			rchk(ea(`CTRL_BASE, j), (j == 1) ? 32'h0000_2000 : 32'h0);
		end
		wr(ea(`CTRL_SET_BASE, 1), 32'h0001_0000);
		dma_want <= 6'h01;
		settle();
		chk1(dma_request[0], 1'b1);
		ev[1].flags <= 8'h10;
		settle();
		chk1(dma_request[0], 1'b0);
		chk1(dma_pause_now[0], 1'b1);
		ev[1].flags <= 8'h02;
		dma_on_prev <= 6'h01;
		settle();
		chk1(dma_request[0], 1'b0);
		chk1(dma_pause_now[0], 1'b0);
		wr(ea(`CTRL_CLR_BASE, 1), 32'h0001_0000);
		settle();
		chk1(dma_request[0], 1'b1);
		ev[1] <= '0;
		for (int c = 0; c < 6; c++)
		begin
			r = nxt(r);
			wr(`NEXTDESC_BASE + 12'(16 * c), r);
			rchk(`NEXTDESC_BASE + 12'(16 * c), {r[31:4], 4'h0});
		end
		// write then read with no gap, read data for one cycle only
		@(posedge sys_clk);
		bus_addr  <= `NEXTDESC_BASE + 12'h050;
		bus_wdata <= 32'hA5C3_0F1E;
		bus_wr    <= 1'b1;
		@(posedge sys_clk);
		bus_wr <= 1'b0;
		bus_rd <= 1'b1;
		@(posedge sys_clk);
		bus_rd <= 1'b0;
		#1 chk32(bus_rdata, 32'hA5C3_0F10);
		@(posedge sys_clk);
		#1 chk32(bus_rdata, 32'h0);
		@(posedge sys_clk);
		desc_addr[2] <= 28'h123_4567;
		desc_load <= 6'h04;
		@(posedge sys_clk);
		desc_load <= 6'h00;
		#1 chk32({next_descriptor_pointer[2], 4'h0}, 32'h1234_5670);
		close_out();
	end
endmodule
`default_nettype wire
